// [rtl/user_flash_serial_port.sv]
`timescale 1ns/1ps
module user_flash_serial_port
#(
   parameter int PROG_TICKS = flash_port_pkg::PROG_TICKS_DEF,
   parameter int ERASE_TICKS = flash_port_pkg::ERASE_TICKS_DEF
)
(
   input wire logic clk,
   input wire logic arst_n,
   input wire logic addr_shift_clk,
   input wire logic addr_shift_ctl,
   input wire logic addr_serial_in,
   input wire logic data_shift_clk,
   input wire logic data_shift_ctl,
   input wire logic data_serial_in,
   output logic data_serial_out,
   input wire logic program_req,
   input wire logic erase_req,
   output logic busy,
   input wire logic osc_enable,
   output logic osc_div_out,
   input wire logic scan_prog,
   input wire logic [flash_port_pkg::ADDR_W-1:0] scan_addr,
   input wire logic [flash_port_pkg::DATA_W-1:0] scan_wdata,
   output logic [flash_port_pkg::DATA_W-1:0] scan_rdata,
   output logic sys_prog_busy
);
   import flash_port_pkg::*;

   // ----------------------------------------------------------------
   // State
   // ----------------------------------------------------------------
   typedef struct packed {
      logic [WORDS-1:0][DATA_W-1:0] mem;
      logic [ADDR_W-1:0] areg;
      logic [DATA_W-1:0] dreg;
      logic a_clk_d;
      logic d_clk_d;
      op_state_type st;
      logic [CNT_W-1:0] op_cnt;
      logic [ADDR_W-1:0] op_addr;
      logic [DATA_W-1:0] op_data;
      logic [DIV_W-1:0] div_cnt;
      logic tick;
      logic [OSC_PH_W-1:0] osc_ph;
      logic osc_out;
      logic busy;
      logic sys_busy;
      logic [DATA_W-1:0] scan_rdata;
   } state_type;

   localparam logic [DIV_W-1:0] TICK_LAST = DIV_W'(OSC_TICK_CYCLES - 1);
   localparam logic [CNT_W-1:0] PROG_LAST = CNT_W'(PROG_TICKS - 1);
   localparam logic [CNT_W-1:0] ERASE_LAST = CNT_W'(ERASE_TICKS - 1);

   state_type s;
   state_type next_s;
   logic [PIN_W-1:0] pin_s;
   logic a_rise;
   logic d_rise;
   logic req_any;

   // ----------------------------------------------------------------
   // Pin synchronisers and edge detection
   // ----------------------------------------------------------------
   // Clock, control and data lines share one delay, so they stay aligned
   pin_sync #(.W(PIN_W)) u_pin_sync
   (
      .clk(clk),
      .arst_n(arst_n),
      .d({osc_enable, erase_req, program_req, data_serial_in, data_shift_ctl,
          data_shift_clk, addr_serial_in, addr_shift_ctl, addr_shift_clk}),
      .q(pin_s)
   );

   assign a_rise = pin_s[PIN_ACLK] & ~s.a_clk_d;
   assign d_rise = pin_s[PIN_DCLK] & ~s.d_clk_d;
   assign req_any = pin_s[PIN_PROG] | pin_s[PIN_ERASE] | scan_prog;

   // ----------------------------------------------------------------
   // Next-state logic
   // ----------------------------------------------------------------
   always_comb
   begin
      next_s = s;
      next_s.a_clk_d = pin_s[PIN_ACLK];
      next_s.d_clk_d = pin_s[PIN_DCLK];

      // Free-running internal oscillator, one tick per period
      if (s.div_cnt == TICK_LAST)
      begin
         next_s.div_cnt = '0;
         next_s.tick = 1'b1;
      end
      else
      begin
         next_s.div_cnt = s.div_cnt + 1'b1;
         next_s.tick = 1'b0;
      end
      // Output is the tick rate over four, gated by enable
      if (s.tick)
      begin
         next_s.osc_ph = s.osc_ph + 1'b1;
      end
      next_s.osc_out = pin_s[PIN_OSCEN] & next_s.osc_ph[OSC_PH_W-1];

      // Address shifter: shift MSB first, or step for a stream
      if (a_rise)
      begin
         if (pin_s[PIN_ACTL])
         begin
            next_s.areg = {s.areg[ADDR_W-2:0], pin_s[PIN_AIN]};
         end
         else
         begin
            next_s.areg = s.areg + 1'b1;
         end
      end

      // Data shifter: parallel load from array, or serial shift
      if (d_rise)
      begin
         if (pin_s[PIN_DCTL])
         begin
            next_s.dreg = {s.dreg[DATA_W-2:0], pin_s[PIN_DIN]};
         end
         else
         begin
            next_s.dreg = s.mem[s.areg];
         end
      end

      // Scan read port sees the array every cycle
      next_s.scan_rdata = s.mem[scan_addr];

      // Program and erase sequencer
      case (s.st)
         st_idle:
         begin
            // Erase outranks program when both rise together
            if (pin_s[PIN_ERASE])
            begin
               next_s.st = st_erase;
               next_s.busy = 1'b1;
               next_s.op_addr = s.areg;
               next_s.op_cnt = ERASE_LAST;
            end
            else if (pin_s[PIN_PROG])
            begin
               next_s.st = st_prog;
               next_s.busy = 1'b1;
               next_s.op_addr = s.areg;
               next_s.op_data = s.dreg;
               next_s.op_cnt = PROG_LAST;
            end
            else if (scan_prog)
            begin
               next_s.st = st_scan;
               next_s.sys_busy = 1'b1;
               next_s.op_addr = scan_addr;
               next_s.op_data = scan_wdata;
               next_s.op_cnt = PROG_LAST;
            end
         end
         st_prog, st_erase, st_scan:
         begin
            // Only oscillator ticks advance the operation
            if (s.tick)
            begin
               if (s.op_cnt == '0)
               begin
                  if (s.st == st_erase)
                  begin
                     // Whole sector of the latched address only
                     for (int i = 0; i < WORDS; i++)
                     begin
                        if (i / SECTOR_WORDS == int'(s.op_addr[SECTOR_BIT]))
                        begin
                           next_s.mem[i] = ERASED_WORD;
                        end
                     end
                  end
                  else
                  begin
                     // Programming only clears bits, hence the prior erase
                     next_s.mem[s.op_addr] = s.mem[s.op_addr] & s.op_data;
                  end
                  next_s.busy = 1'b0;
                  next_s.sys_busy = 1'b0;
                  next_s.st = st_release;
               end
               else
               begin
                  next_s.op_cnt = s.op_cnt - 1'b1;
               end
            end
         end
         st_release:
         begin
            // A still-held request must not start a second operation
            if (!req_any)
            begin
               next_s.st = st_idle;
            end
         end
         default:
         begin
            next_s.st = st_idle;
         end
      endcase
   end

   // ----------------------------------------------------------------
   // State register
   // ----------------------------------------------------------------
   // Array resets to the erased pattern, standing in for a blank part
   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         s <= '0;
         s.mem <= {WORDS{ERASED_WORD}};
         s.st <= st_idle;
      end
      else
      begin
         s <= next_s;
      end
   end

   assign data_serial_out = s.dreg[DATA_W-1];
   assign busy = s.busy;
   assign osc_div_out = s.osc_out;
   assign scan_rdata = s.scan_rdata;
   assign sys_prog_busy = s.sys_busy;

   // ----------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!arst_n);

   a_busy_start: assert property (s.st == st_idle && pin_s[PIN_ERASE] |=> s.busy)
      else $error("busy did not rise on erase request");

   a_busy_early: assert property (
      $fell(s.busy) |-> $past(s.op_cnt) == '0 && $past(s.tick))
      else $error("busy fell before the operation ended");

   a_erase_other: assert property (
      s.st == st_erase && !s.op_addr[SECTOR_BIT]
      |=> s.mem[SECTOR1_FIRST] == $past(s.mem[SECTOR1_FIRST]))
      else $error("erase of sector 0 touched sector 1");

   // Both ends of whichever sector was latched must read blank afterwards
   a_erase_fill: assert property (
      s.st == st_erase && s.tick && s.op_cnt == '0
      |=> s.mem[{$past(s.op_addr[SECTOR_BIT]), LAST_ADDR[SECTOR_BIT-1:0]}] == ERASED_WORD
      && s.mem[{$past(s.op_addr[SECTOR_BIT]), SECTOR0_FIRST[SECTOR_BIT-1:0]}] == ERASED_WORD)
      else $error("sector erase left words unerased");

   a_prog_and: assert property (
      s.st == st_prog && s.tick && s.op_cnt == '0
      |=> s.mem[$past(s.op_addr)] == ($past(s.mem[s.op_addr]) & $past(s.op_data)))
      else $error("programmed word has the wrong value");

   a_addr_incr: assert property (
      a_rise && !pin_s[PIN_ACTL]
      |=> s.areg == $past(s.areg) + 1'b1)
      else $error("address did not step on stream clock");

   a_addr_shift: assert property (
      a_rise && pin_s[PIN_ACTL]
      |=> s.areg == {$past(s.areg[ADDR_W-2:0]), $past(pin_s[PIN_AIN])})
      else $error("address shift wrong");

   a_data_load: assert property (
      d_rise && !pin_s[PIN_DCTL]
      |=> s.dreg == $past(s.mem[s.areg]))
      else $error("data register did not load the addressed word");

   a_data_shift: assert property (
      d_rise && pin_s[PIN_DCTL]
      |=> data_serial_out == $past(s.dreg[DATA_W-2]))
      else $error("serial data output did not advance");

   a_osc_quiet: assert property (!pin_s[PIN_OSCEN] |=> !osc_div_out)
      else $error("oscillator output active while disabled");

   // Enable held two cycles, so the rise cannot be the gate just opening
   a_osc_step: assert property (
      $rose(osc_div_out) && $past(pin_s[PIN_OSCEN], 2)
      |-> $past(s.tick) && $past(s.osc_ph) == OSC_PH_W'(OSC_DIVIDE / 2 - 1))
      else $error("oscillator output rose off its divided tick");

   a_hold_release: assert property (
      s.st == st_release && req_any
      |=> !s.busy && !s.sys_busy)
      else $error("held request restarted an operation");

   c_erase_done: cover property (s.st == st_erase ##1 s.st == st_release);
   c_prog_done: cover property (s.st == st_prog ##1 s.st == st_release);
   c_stream: cover property (a_rise && !pin_s[PIN_ACTL] ##[1:40] d_rise && !pin_s[PIN_DCTL]);
   c_scan_prog: cover property ($fell(sys_prog_busy));
endmodule

// [include/flash_port_pkg.sv]
// ----------------------------------------------------------------
// Shared constants of the serial flash port
// ----------------------------------------------------------------
package flash_port_pkg;
   // Array geometry
   localparam int ADDR_W = 9;
   localparam int DATA_W = 16;
   localparam int WORDS = 512;
   localparam int SECTOR_WORDS = 256;
   localparam int SECTOR_BIT = 8;
   localparam logic [8:0] SECTOR0_FIRST = 9'h000;
   localparam logic [8:0] SECTOR1_FIRST = 9'h100;
   localparam logic [8:0] LAST_ADDR = 9'h1ff;
   localparam logic [15:0] ERASED_WORD = 16'hffff;

   // Timing: internal oscillator paced from the 250 MHz clock
   localparam int CLK_PERIOD_NS = 4;
   localparam int INT_OSC_PERIOD_NS = 56;
   localparam int OSC_TICK_CYCLES = INT_OSC_PERIOD_NS / CLK_PERIOD_NS;
   localparam int OSC_DIVIDE = 4;
   localparam int OSC_PH_W = $clog2(OSC_DIVIDE);
   localparam int DIV_W = $clog2(OSC_TICK_CYCLES);

   // Operation lengths in oscillator ticks
   localparam int CNT_W = 16;
   localparam int PROG_TICKS_DEF = 8;
   localparam int ERASE_TICKS_DEF = 64;

   // Bit positions of the synchronised pin vector
   localparam int PIN_W = 9;
   localparam int PIN_ACLK = 0;
   localparam int PIN_ACTL = 1;
   localparam int PIN_AIN = 2;
   localparam int PIN_DCLK = 3;
   localparam int PIN_DCTL = 4;
   localparam int PIN_DIN = 5;
   localparam int PIN_PROG = 6;
   localparam int PIN_ERASE = 7;
   localparam int PIN_OSCEN = 8;

   typedef enum logic [2:0] {
      st_idle,
      st_prog,
      st_erase,
      st_scan,
      st_release
   } op_state_type;
endpackage

// [rtl/pin_sync.sv]
`timescale 1ns/1ps
// ----------------------------------------------------------------
// Two-stage synchroniser for pins from outside the clock domain
// ----------------------------------------------------------------
module pin_sync
#(
   parameter int W = 1
)
(
   input wire logic clk,
   input wire logic arst_n,
   input wire logic [W-1:0] d,
   output logic [W-1:0] q
);
   typedef struct packed {
      logic [W-1:0] meta;
      logic [W-1:0] q;
   } sync_state_type;

   sync_state_type s;
   sync_state_type next_s;

   // First stage feeds only the second stage
   always_comb
   begin
      next_s = s;
      next_s.meta = d;
      next_s.q = s.meta;
   end

   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         s <= '0;
      end
      else
      begin
         s <= next_s;
      end
   end

   assign q = s.q;
endmodule

// [tb/fabric_master.sv]
`timescale 1ns/1ps
// ----------------------------------------------------------------
// Fabric user logic driving the flash port pins
// ----------------------------------------------------------------
module fabric_master
(
   input wire logic clk,
   input wire logic busy,
   input wire logic dout,
   output logic aclk,
   output logic actl,
   output logic ain,
   output logic dclk,
   output logic dctl,
   output logic din,
   output logic prog,
   output logic ers
);
   // Pins idle low at time zero
   initial
   begin
      {aclk, actl, ain, dclk, dctl, din, prog, ers} = 8'h00;
   end

   // Pins move on falling clk; 4 cycles per level beats the 2-stage sync
   task automatic hold4();
      repeat (4) @(negedge clk);
   endtask

   // One address clock: ctl high shifts, low steps the address
   task automatic apulse(input logic ctl, input logic d);
      actl = ctl;
      ain = d;
      hold4();
      aclk = 1'b1;
      hold4();
      aclk = 1'b0;
      ain = ~d; // Serial line undefined now: show a changing value
      hold4();
   endtask

   // One data clock: ctl low loads the word, high shifts a bit
   task automatic dpulse(input logic ctl, input logic d);
      dctl = ctl;
      din = d;
      hold4();
      dclk = 1'b1;
      hold4();
      dclk = 1'b0;
      din = ~d;
      hold4();
   endtask

   // Address goes in MSB first
   task automatic load_addr(input logic [8:0] a);
      for (int i = 8; i >= 0; i--)
         apulse(1'b1, a[i]);
   endtask

   // Word goes in MSB first so it lands at bit 15 after 16 edges
   task automatic send_word(input logic [15:0] w);
      for (int i = 15; i >= 0; i--)
         dpulse(1'b1, w[i]);
   endtask

   // Load, then shift out bit 15 down to bit 0
   task automatic read_word(output logic [15:0] w);
      dpulse(1'b0, 1'b0);
      w[15] = dout;
      for (int i = 14; i >= 0; i--)
      begin
         dpulse(1'b1, 1'b0);
         w[i] = dout;
      end
   endtask

   // Request held until busy falls; returns cycles busy stood high
   task automatic request(input logic erase, output int high);
      int w;
      w = 0;
      high = 0;
      if (erase)
         ers = 1'b1;
      else
         prog = 1'b1;
      while (busy !== 1'b1 && w < 10)
      begin
         @(negedge clk);
         w++;
      end
      while (busy === 1'b1 && high < 400)
      begin
         @(negedge clk);
         high++;
      end
      prog = 1'b0;
      ers = 1'b0;
      hold4();
   endtask
endmodule

// [tb/tb.sv]
`timescale 1ns/1ps
// ----------------------------------------------------------------
// Self-checking bench of the serial flash port
// ----------------------------------------------------------------
module tb;
   import flash_port_pkg::*;
   localparam int PROG_N = 2;
   localparam int ERASE_N = 4;
   localparam int LIMIT = 20000;
   logic clk = 1'b0;
   logic arst_n = 1'b0;
   logic osc_enable = 1'b0;
   logic scan_prog = 1'b0;
   logic [ADDR_W-1:0] scan_addr = 9'h000;
   logic [DATA_W-1:0] scan_wdata = 16'h0000;
   logic [DATA_W-1:0] scan_rdata;
   logic aclk, actl, ain, dclk, dctl, din, dout, prog, ers, busy, osc, spb;
   logic [15:0] w;
   logic ok;
   int n_mismatch = 0;
   int n_compared = 0;
   int cycles = 0;
   int n;

   user_flash_serial_port #(.PROG_TICKS(PROG_N), .ERASE_TICKS(ERASE_N)) u_dut (
      .clk(clk), .arst_n(arst_n), .addr_shift_clk(aclk), .addr_shift_ctl(actl),
      .addr_serial_in(ain), .data_shift_clk(dclk), .data_shift_ctl(dctl),
      .data_serial_in(din), .data_serial_out(dout), .program_req(prog),
      .erase_req(ers), .busy(busy), .osc_enable(osc_enable), .osc_div_out(osc),
      .scan_prog(scan_prog), .scan_addr(scan_addr), .scan_wdata(scan_wdata),
      .scan_rdata(scan_rdata), .sys_prog_busy(spb));

   fabric_master u_user (
      .clk(clk), .busy(busy), .dout(dout), .aclk(aclk), .actl(actl), .ain(ain),
      .dclk(dclk), .dctl(dctl), .din(din), .prog(prog), .ers(ers));

   // Clock and hang guard
   initial
   begin
      forever #2 clk = ~clk;
   end
   always @(posedge clk)
   begin
      cycles++;
      if (cycles == LIMIT)
      begin
         n_mismatch++;
         close_out();
      end
   end

   task automatic check(input string what, input logic [15:0] seen,
                        input logic [15:0] exp);
      n_compared++;
      if (seen !== exp)
      begin
         n_mismatch++;
         $display("BAD %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic close_out();
      $display("Compared %0d, mismatches %0d", n_compared, n_mismatch);
      if (n_mismatch == 0 && n_compared > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask

   // Scan side program: hold request until its busy falls
   task automatic scan_write(input logic [8:0] a, input logic [15:0] d);
      int k;
      k = 0;
      scan_addr = a;
      scan_wdata = d;
      scan_prog = 1'b1;
      while (spb !== 1'b1 && k < 10)
      begin
         @(negedge clk);
         k++;
      end
      check("spb_up", 16'(spb), 16'h0001);
      while (spb === 1'b1 && k < 400)
      begin
         @(negedge clk);
         k++;
      end
      check("spb_down", 16'(spb), 16'h0000);
      scan_prog = 1'b0;
      repeat (2) @(negedge clk);
   endtask

   task automatic scan_read(input logic [8:0] a, output logic [15:0] d);
      scan_addr = a;
      repeat (2) @(negedge clk);
      d = scan_rdata;
   endtask

   // Blank last word, busy and oscillator low after reset
   task automatic t_reset();
      check("busy", 16'(busy), 16'h0000);
      check("osc", 16'(osc), 16'h0000);
      scan_read(LAST_ADDR, w);
      check("blank", w, ERASED_WORD);
   endtask

   // Scan writes at sector edges, then serial single and stream reads
   task automatic t_stream();
      scan_write(9'h0ff, 16'h1234);
      scan_write(9'h100, 16'h5678);
      scan_write(9'h1ff, 16'ha5c3);
      scan_read(9'h100, w);
      check("scan_rd", w, 16'h5678);
      u_user.load_addr(9'h0ff);
      u_user.read_word(w);
      check("rd_0ff", w, 16'h1234);
      u_user.apulse(1'b0, 1'b0);
      u_user.read_word(w);
      check("rd_100", w, 16'h5678);
      u_user.load_addr(9'h1ff);
      u_user.read_word(w);
      check("rd_1ff", w, 16'ha5c3);
      u_user.apulse(1'b0, 1'b0);
      u_user.read_word(w);
      check("rd_wrap", w, ERASED_WORD);
   endtask

   // Serial program of a blank word with busy handshake
   task automatic t_program();
      u_user.load_addr(9'h005);
      u_user.send_word(16'h3c96);
      u_user.request(1'b0, n);
      ok = n >= (PROG_N - 1) * OSC_TICK_CYCLES && n <= (PROG_N + 1) * OSC_TICK_CYCLES;
      check("prog_len", 16'(ok), 16'h0001);
      scan_read(9'h005, w);
      check("prog_word", w, 16'h3c96);
   endtask

   // Sector 0 erase leaves sector 1 alone
   task automatic t_erase();
      u_user.load_addr(9'h010);
      u_user.request(1'b1, n);
      ok = n >= (ERASE_N - 1) * OSC_TICK_CYCLES && n <= (ERASE_N + 1) * OSC_TICK_CYCLES;
      check("erase_len", 16'(ok), 16'h0001);
      scan_read(9'h0ff, w);
      check("erased_0ff", w, ERASED_WORD);
      scan_read(9'h005, w);
      check("erased_005", w, ERASED_WORD);
      scan_read(9'h100, w);
      check("kept_100", w, 16'h5678);
      // Reprogram inside the freshly erased sector
      u_user.load_addr(9'h005);
      u_user.send_word(16'h0f0f);
      u_user.request(1'b0, n);
      scan_read(9'h005, w);
      check("reprog_005", w, 16'h0f0f);
      scan_read(9'h1ff, w);
      check("kept_1ff", w, 16'ha5c3);
   endtask

   // Divided oscillator period, then gated off
   task automatic t_osc();
      int k;
      k = 0;
      osc_enable = 1'b1;
      // First high phase may be cut short by the enable gate: skip it
      while (osc !== 1'b1 && k < 200)
      begin
         @(negedge clk);
         k++;
      end
      while (osc === 1'b1 && k < 200)
      begin
         @(negedge clk);
         k++;
      end
      n = 0;
      while (osc === 1'b0 && n < 200)
      begin
         @(negedge clk);
         n++;
      end
      while (osc === 1'b1 && n < 200)
      begin
         @(negedge clk);
         n++;
      end
      check("osc_period", 16'(n), 16'(OSC_TICK_CYCLES * OSC_DIVIDE));
      osc_enable = 1'b0;
      repeat (70) @(negedge clk);
      check("osc_off", 16'(osc), 16'h0000);
   endtask

   // Main sequence
   initial
   begin
      repeat (16) @(negedge clk);
      arst_n = 1'b1;
      repeat (4) @(negedge clk);
      t_reset();
      t_stream();
      t_program();
      t_erase();
      t_osc();
      close_out();
   end
endmodule
